// *** rtl/vjd_regs.svh ***
// Constants of the vector jump islanding detector
`ifndef VJD_REGS_SVH
`define VJD_REGS_SVH
`define VJD_CLK_HZ          100000000
`define VJD_SAMPLES_CYCLE   64
`define VJD_TRIP_HOLD_MS    20
`define VJD_STAMP_RES_MS    1
`define VJD_MS_CYCLES       (`VJD_CLK_HZ / 1000 * `VJD_STAMP_RES_MS)
`define VJD_SET_COUNT       8
`define VJD_ANGLE_W         16
`define VJD_VOLT_W          16
`define VJD_CNT_W           16
`define VJD_STAMP_W         32
`define VJD_CODE_NORMAL     2'h0
`define VJD_CODE_BLOCKED    2'h1
`define VJD_CODE_TRIP       2'h2
`define VJD_CODE_ALARM      2'h3
`define VJD_EVT_ALARM       2'h0
`define VJD_EVT_TRIP        2'h1
`define VJD_EVT_BLOCKED     2'h2
`define VJD_RST_THR         16'h01F4
`define VJD_RST_UV          16'h251C
`define VJD_RST_SEL         4'h1
`endif

// *** rtl/vjd_pkg.sv ***
// Types of the vector jump islanding detector
package vjd_pkg;
   typedef enum logic [3:0] {
      SEL_ALL_PP, SEL_ANY_PP, SEL_L12, SEL_L23, SEL_L31,
      SEL_ALL_PN, SEL_ANY_PN, SEL_L1, SEL_L2, SEL_L3, SEL_U4
   } vjd_sel_e;
   typedef enum logic [1:0] {ST_NORMAL, ST_BLOCKED, ST_TRIP, ST_ALARM} vjd_state_e;
   typedef struct packed {
      logic [15:0] tripThr;
      logic [15:0] alarmThr;
      logic [15:0] uvLimit;
      logic [3:0]  monSel;
   } vjd_set_s;
endpackage

// *** rtl/vjd_chan_if.sv ***
// Interface carrying per-channel angle jump results
`timescale 1ns/100ps
interface vjd_chan_if;
   logic [6:0]  valid;
   logic [6:0]  alarmHit;
   logic [6:0]  tripHit;
   modport src (output valid, output alarmHit, output tripHit);
   modport dst (input valid, input alarmHit, input tripHit);
endinterface

// *** rtl/vjd_jump_calc.sv ***
// Cycle-to-cycle angle change per channel, compared against both thresholds
`timescale 1ns/100ps
`include "vjd_regs.svh"
module vjd_jump_calc (
   input  wire logic                                 clk,
   input  wire logic                                 nrst,
   input  wire logic                                 sampleEn,
   input  wire logic [7*`VJD_ANGLE_W-1:0]            angleIn,
   input  wire logic [15:0]                          alarmThr,
   input  wire logic [15:0]                          tripThr,
   vjd_chan_if.src                                   res
);
   logic [5:0] sampleCnt_q;
   logic       primed_q;
   logic       cycleEnd;

   // Sample counter marks one power-system cycle every 64 samples
   assign cycleEnd = sampleEn && (sampleCnt_q == 6'(`VJD_SAMPLES_CYCLE - 1));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sampleCnt_q <= 6'h00;
         primed_q    <= 1'b0;
      end else if (sampleEn) begin
         sampleCnt_q <= sampleCnt_q + 6'h01;
         if (cycleEnd) primed_q <= 1'b1;
      end
   end

   genvar i;
   generate
      for (i = 0; i < 7; i++) begin : gChan
         logic [15:0] prev_q;
         logic [15:0] cur;
         logic [15:0] diff;
         logic [15:0] mag;
         assign cur  = angleIn[i*16 +: 16];
         // Wraparound subtract keeps lead and lag symmetric across the 0/360 seam
         assign diff = cur - prev_q;
         assign mag  = diff[15] ? 16'(-diff) : diff;
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               prev_q          <= 16'h0000;
               res.valid[i]    <= 1'b0;
               res.alarmHit[i] <= 1'b0;
               res.tripHit[i]  <= 1'b0;
            end else if (cycleEnd) begin
               prev_q          <= cur;
               res.valid[i]    <= primed_q;
               res.alarmHit[i] <= primed_q && (mag >= alarmThr);
               res.tripHit[i]  <= primed_q && (mag >= tripThr);
            end else begin
               res.valid[i]    <= 1'b0;
               res.alarmHit[i] <= 1'b0;
               res.tripHit[i]  <= 1'b0;
            end
         end
      end
   endgenerate
endmodule

// *** rtl/vjd_detector.sv ***
// Vector jump islanding detector top
// How it works
// - One instantaneous stage, no graded stages
// - Tracks voltages at 64 samples per cycle
// - Reference: all, any or one phase voltage, or the fourth input
// - Outputs alarm, trip and blocked
// - Separate alarm and trip pick-up thresholds
// - Eight parameter sets, one selector
// - Block and set select change live
// - Undervoltage or external block blocks detector
// - Select, process, compare, block, time, output
// - Stamped on/off events for each output
// - Trip logs alarm and trip, same stamp
// - Event stamps resolve to one millisecond
// - Clearable counters for alarm, trip, blocked
// - Outputs exposed for pins and logic
// - Trip held 20 ms then auto-clears
// - Below undervoltage limit blocks detector
// - Start only while not blocked
// - Two-bit state code, also forceable
`timescale 1ns/100ps
`include "vjd_regs.svh"
module vjd_detector #(
   parameter int unsigned MS_CYCLES = `VJD_MS_CYCLES
) (
   input  wire logic                               clk,
   input  wire logic                               nrst,
   input  wire logic                               sampleEn,
   input  wire logic [7*`VJD_ANGLE_W-1:0]          angleIn,
   input  wire logic [7*`VJD_VOLT_W-1:0]           magIn,
   input  wire logic [2:0]                         setSel,
   input  wire logic                               setWrEn,
   input  wire logic [2:0]                         setWrIdx,
   input  wire vjd_pkg::vjd_set_s                  setWrData,
   input  wire logic                               alarmEnable,
   input  wire logic                               extBlock,
   input  wire logic                               forceEn,
   input  wire logic [1:0]                         forceCode,
   input  wire logic [2:0]                         cntClear,
   output logic                                    alarmOut,
   output logic                                    tripOut,
   output logic                                    blockedOut,
   output logic                                    startOut,
   output logic [1:0]                              stateCode,
   output logic                                    selInvalid,
   output logic                                    evtValid,
   output logic [1:0]                              evtSource,
   output logic                                    evtOn,
   output logic [`VJD_STAMP_W-1:0]                 evtStamp,
   output logic [`VJD_CNT_W-1:0]                   alarmCnt,
   output logic [`VJD_CNT_W-1:0]                   tripCnt,
   output logic [`VJD_CNT_W-1:0]                   blockedCnt
);
   localparam int unsigned HOLD_CYCLES = `VJD_TRIP_HOLD_MS * MS_CYCLES;

   ////////////////////////////////////////////////////////////////////////////////
   // Parameter sets
   vjd_pkg::vjd_set_s sets_q [`VJD_SET_COUNT];
   vjd_pkg::vjd_set_s act;
   vjd_chan_if        chan ();

   // Eight sets written any time; selector applies in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int k = 0; k < `VJD_SET_COUNT; k++) begin
            sets_q[k] <= '{`VJD_RST_THR, `VJD_RST_THR, `VJD_RST_UV, `VJD_RST_SEL};
         end
      end else if (setWrEn) begin
         sets_q[setWrIdx] <= setWrData;
      end
   end
   assign act = sets_q[setSel];

   ////////////////////////////////////////////////////////////////////////////////
   // Channel selection: bits 0..2 phase-phase, 3..5 phase-neutral, 6 fourth input
   function automatic logic [6:0] chanMask(input logic [3:0] sel);
      case (sel)
         4'h0, 4'h1: chanMask = 7'h07;
         4'h2:       chanMask = 7'h01;
         4'h3:       chanMask = 7'h02;
         4'h4:       chanMask = 7'h04;
         4'h5, 4'h6: chanMask = 7'h38;
         4'h7:       chanMask = 7'h08;
         4'h8:       chanMask = 7'h10;
         4'h9:       chanMask = 7'h20;
         4'hA:       chanMask = 7'h40;
         default:    chanMask = 7'h00;
      endcase
   endfunction
   function automatic logic needAll(input logic [3:0] sel);
      needAll = (sel == 4'h0) || (sel == 4'h5);
   endfunction

   logic [6:0] mask;
   assign mask       = chanMask(act.monSel);
   assign selInvalid = (mask == 7'h00);

   ////////////////////////////////////////////////////////////////////////////////
   // Angle processing stage
   vjd_jump_calc uCalc (
      .clk      (clk),
      .nrst     (nrst),
      .sampleEn (sampleEn),
      .angleIn  (angleIn),
      .alarmThr (act.alarmThr),
      .tripThr  (act.tripThr),
      .res      (chan)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison reduce and block checks
   logic [6:0] uvLow;
   logic [6:0] uvLow_q;
   logic       anyValid;
   logic       alarmPick;
   logic       tripPick;
   logic       uvBlock;
   logic       blocked;
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : gUv
         assign uvLow[g] = magIn[g*16 +: 16] < act.uvLimit;
      end
   endgenerate
   // Magnitudes are only valid on a strobe, so the low flags hold between samples
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         uvLow_q <= 7'h00;
      end else if (sampleEn) begin
         uvLow_q <= uvLow;
      end
   end
   assign anyValid  = |(chan.valid & mask);
   assign alarmPick = anyValid && (needAll(act.monSel) ?
                      ((chan.alarmHit & mask) == mask) : |(chan.alarmHit & mask));
   assign tripPick  = anyValid && (needAll(act.monSel) ?
                      ((chan.tripHit & mask) == mask) : |(chan.tripHit & mask));
   assign uvBlock   = |(uvLow_q & mask);
   assign blocked   = uvBlock || extBlock;

   ////////////////////////////////////////////////////////////////////////////////
   // Millisecond time base and stamp
   logic [31:0] msDiv_q;
   logic        msTick;
   logic [`VJD_STAMP_W-1:0] stamp_q;
   assign msTick = (msDiv_q == MS_CYCLES - 1);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         msDiv_q <= 32'h00000000;
         stamp_q <= '0;
      end else if (msTick) begin
         msDiv_q <= 32'h00000000;
         stamp_q <= stamp_q + 1'b1;
      end else begin
         msDiv_q <= msDiv_q + 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Single stage: trip hold timer and alarm level
   logic [31:0] holdCnt_q;
   logic        tripRaw_q;
   logic        alarmRaw_q;
   logic        tripStart;
   assign tripStart = tripPick && !blocked && !tripRaw_q;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tripRaw_q <= 1'b0;
         holdCnt_q <= 32'h00000000;
      end else if (tripStart) begin
         tripRaw_q <= 1'b1;
         holdCnt_q <= 32'h00000000;
      end else if (tripRaw_q) begin
         if (holdCnt_q == HOLD_CYCLES - 1) begin
            tripRaw_q <= 1'b0;
         end else begin
            holdCnt_q <= holdCnt_q + 32'h00000001;
         end
      end
   end
   // Alarm also picks up on a trip compare; with alarmEnable set, a trip always carries an alarm
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarmRaw_q <= 1'b0;
      end else if (!alarmEnable || blocked) begin
         alarmRaw_q <= 1'b0;
      end else if (anyValid) begin
         alarmRaw_q <= alarmPick || tripPick;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output processing with forcing and state code
   logic aNext;
   logic tNext;
   logic bNext;
   always_comb begin
      aNext = alarmRaw_q || (tripRaw_q && alarmEnable);
      tNext = tripRaw_q;
      bNext = blocked;
      if (forceEn) begin
         aNext = (forceCode == `VJD_CODE_ALARM);
         tNext = (forceCode == `VJD_CODE_TRIP);
         bNext = (forceCode == `VJD_CODE_BLOCKED);
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarmOut   <= 1'b0;
         tripOut    <= 1'b0;
         blockedOut <= 1'b0;
         startOut   <= 1'b0;
         stateCode  <= `VJD_CODE_NORMAL;
      end else begin
         alarmOut   <= aNext;
         tripOut    <= tNext;
         blockedOut <= bNext;
         startOut   <= (aNext || tNext) && !bNext;
         if (tNext)      stateCode <= `VJD_CODE_TRIP;
         else if (aNext) stateCode <= `VJD_CODE_ALARM;
         else if (bNext) stateCode <= `VJD_CODE_BLOCKED;
         else            stateCode <= `VJD_CODE_NORMAL;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Events: edges of the three outputs, drained one per cycle by priority
   logic [2:0] prevOut_q;
   logic [2:0] pend_q;
   logic [2:0] pendOn_q;
   logic [`VJD_STAMP_W-1:0] pendStamp_q [3];
   logic [2:0] curOut;
   logic [2:0] edgeV;
   logic [2:0] grant;
   assign curOut = {blockedOut, tripOut, alarmOut};
   assign edgeV  = curOut ^ prevOut_q;
   always_comb begin
      grant = 3'h0;
      if (pend_q[1])      grant = 3'h2;
      else if (pend_q[0]) grant = 3'h1;
      else if (pend_q[2]) grant = 3'h4;
   end
   // New edge wins over the drain of the same pending slot
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prevOut_q <= 3'h0;
         pend_q    <= 3'h0;
         pendOn_q  <= 3'h0;
         for (int k = 0; k < 3; k++) pendStamp_q[k] <= '0;
      end else begin
         prevOut_q <= curOut;
         for (int k = 0; k < 3; k++) begin
            if (edgeV[k]) begin
               pend_q[k]      <= 1'b1;
               pendOn_q[k]    <= curOut[k];
               pendStamp_q[k] <= stamp_q;
            end else if (grant[k]) begin
               pend_q[k] <= 1'b0;
            end
         end
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         evtValid  <= 1'b0;
         evtSource <= `VJD_EVT_ALARM;
         evtOn     <= 1'b0;
         evtStamp  <= '0;
      end else begin
         evtValid <= |grant;
         if (grant[1]) begin
            evtSource <= `VJD_EVT_TRIP;
            evtOn     <= pendOn_q[1];
            evtStamp  <= pendStamp_q[1];
         end else if (grant[0]) begin
            evtSource <= `VJD_EVT_ALARM;
            evtOn     <= pendOn_q[0];
            evtStamp  <= pendStamp_q[0];
         end else if (grant[2]) begin
            evtSource <= `VJD_EVT_BLOCKED;
            evtOn     <= pendOn_q[2];
            evtStamp  <= pendStamp_q[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Cumulative counters, rising edges counted, clear with a same-cycle count gives one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         alarmCnt   <= '0;
         tripCnt    <= '0;
         blockedCnt <= '0;
      end else begin
         if (edgeV[0] && curOut[0]) alarmCnt <= (cntClear[0] ? '0 : alarmCnt) + 1'b1;
         else if (cntClear[0])      alarmCnt <= '0;
         if (edgeV[1] && curOut[1]) tripCnt <= (cntClear[1] ? '0 : tripCnt) + 1'b1;
         else if (cntClear[1])      tripCnt <= '0;
         if (edgeV[2] && curOut[2]) blockedCnt <= (cntClear[2] ? '0 : blockedCnt) + 1'b1;
         else if (cntClear[2])      blockedCnt <= '0;
      end
   end
endmodule

// *** sim/vjd_front_end.sv ***
// Behavioural voltage front end: sample strobe, angles and magnitudes
`timescale 1ns/100ps
module vjd_front_end (
   input  wire logic          clk,
   input  wire logic          nrst,
   input  wire logic          jumpGo,
   input  wire logic [15:0]   jumpStep,
   input  wire logic [15:0]   magLevel,
   input  wire logic [15:0]   magL12,
   output logic               sampleEn,
   output logic [111:0]       angleIn,
   output logic [111:0]       magIn
);
   logic [1:0]   div_q;
   logic [15:0]  offset_q;
   logic [111:0] ang;
   logic [111:0] mag;
   ////////////////////////////////////////
   // Strobe every 4 clocks keeps a 64-sample power cycle at 256 clocks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_q    <= 2'h0;
         offset_q <= 16'h0000;
      end else begin
         div_q <= div_q + 2'h1;
         if (jumpGo) begin
            offset_q <= offset_q + jumpStep;
         end
      end
   end
   assign sampleEn = (div_q == 2'h3);
   // Phasors seen from the tracked frequency stand still; a jump shifts all of them
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         ang[i*16 +: 16] = 16'(i * 16'h2492) + offset_q;
      end
   end
   // Lines carry garbage between strobes, so a design must not sample them there
   assign mag     = {{6{magLevel}}, magL12};
   assign angleIn = sampleEn ? ang : ~ang;
   assign magIn   = sampleEn ? mag : ~mag;
endmodule

// *** sim/vjd_detector_sva.sv ***
// Port assertions of the vector jump islanding detector
`timescale 1ns/100ps
`include "vjd_regs.svh"
module vjd_detector_sva #(
   parameter int unsigned MS_CYCLES = `VJD_MS_CYCLES
) (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        alarmEnable,
   input wire logic        extBlock,
   input wire logic        forceEn,
   input wire logic        alarmOut,
   input wire logic        tripOut,
   input wire logic        blockedOut,
   input wire logic        startOut,
   input wire logic [1:0]  stateCode,
   input wire logic        evtValid,
   input wire logic [1:0]  evtSource,
   input wire logic        evtOn,
   input wire logic [31:0] evtStamp
);
   localparam int unsigned HOLD = `VJD_TRIP_HOLD_MS * MS_CYCLES;
   logic [31:0] holdCnt_q;
   logic [31:0] onStamp_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   // Trip pulse length and last trip-on stamp, so the end of a hold is judged once
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         holdCnt_q <= 32'h0;
         onStamp_q <= 32'h0;
      end else begin
         holdCnt_q <= tripOut ? holdCnt_q + 32'h1 : 32'h0;
         if (evtValid && evtOn && evtSource == `VJD_EVT_TRIP) begin
            onStamp_q <= evtStamp;
         end
      end
   end
   ////////////////////////////////////////
   property p_trip_hold;
      $fell(tripOut) && !forceEn |-> holdCnt_q == HOLD;
   endproperty
   a_trip_hold: assert property (p_trip_hold)
      else $error("trip pulse length wrong");
   property p_trip_max;
      holdCnt_q <= HOLD;
   endproperty
   a_trip_max: assert property (p_trip_max)
      else $error("trip pulse too long");
   property p_trip_evt;
      $rose(tripOut) && !forceEn |-> ##[1:2] (evtValid && evtOn && evtSource == `VJD_EVT_TRIP);
   endproperty
   a_trip_evt: assert property (p_trip_evt)
      else $error("trip on event missing");
   property p_pair;
      evtValid && evtOn && evtSource == `VJD_EVT_TRIP && alarmEnable && !forceEn |=>
         evtValid && evtOn && evtSource == `VJD_EVT_ALARM && $stable(evtStamp);
   endproperty
   a_pair: assert property (p_pair)
      else $error("alarm event not paired with trip");
   property p_stamp;
      evtValid && !evtOn && evtSource == `VJD_EVT_TRIP && !forceEn |->
         evtStamp - onStamp_q == `VJD_TRIP_HOLD_MS;
   endproperty
   a_stamp: assert property (p_stamp)
      else $error("trip off stamp not hold apart");
   property p_start_blk;
      startOut |-> !blockedOut;
   endproperty
   a_start_blk: assert property (p_start_blk)
      else $error("start while blocked");
   property p_ext_blk;
      $rose(extBlock) && !forceEn |-> ##[1:300] blockedOut;
   endproperty
   a_ext_blk: assert property (p_ext_blk)
      else $error("external block not shown");
   property p_state_trip;
      tripOut && !forceEn && !$past(forceEn) |-> stateCode == `VJD_CODE_TRIP;
   endproperty
   a_state_trip: assert property (p_state_trip)
      else $error("state code not trip");
   property p_alarm_en;
      $rose(alarmOut) && !forceEn |-> alarmEnable;
   endproperty
   a_alarm_en: assert property (p_alarm_en)
      else $error("alarm while trip only");
endmodule

// *** sim/vjd_detector_tb.sv ***
// Self-checking bench of the vector jump islanding detector
`timescale 1ns/100ps
`include "vjd_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("unexpected %s exp %0h got %0h", n, e, g); end end
`define WAITV(s, v, n) for (int w = 0; w < n && s !== v; w++) tick(1);
module vjd_detector_tb;
   logic              clk, nrst, jumpGo, setWrEn, alarmEnable, extBlock, forceEn, sampleEn;
   logic              alarmOut, tripOut, blockedOut, startOut, selInvalid, evtValid, evtOn;
   logic [15:0]       jumpStep, magLevel, magL12, alarmCnt, tripCnt, blockedCnt;
   logic [15:0]       expA, expT, expB;
   logic [2:0]        setSel, setWrIdx, cntClear;
   logic [1:0]        forceCode, stateCode, evtSource;
   logic [111:0]      angleIn, magIn;
   logic [31:0]       evtStamp;
   logic [34:0]       evQ[$];
   vjd_pkg::vjd_set_s setWrData;
   int                failures, checked, cycles;
   vjd_front_end frontEnd (.clk, .nrst, .jumpGo, .jumpStep, .magLevel, .magL12, .sampleEn,
      .angleIn, .magIn);
   vjd_detector #(.MS_CYCLES(10)) DUT (.clk, .nrst, .sampleEn, .angleIn, .magIn, .setSel,
      .setWrEn, .setWrIdx, .setWrData, .alarmEnable, .extBlock, .forceEn, .forceCode,
      .cntClear, .alarmOut, .tripOut, .blockedOut, .startOut, .stateCode, .selInvalid,
      .evtValid, .evtSource, .evtOn, .evtStamp, .alarmCnt, .tripCnt, .blockedCnt);
   ////////////////////////////////////////
   // Clock, event log and hang guard
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (evtValid === 1'b1) evQ.push_back({evtSource, evtOn, evtStamp});
      if (cycles == 30000) begin
         failures++;
         end_sim();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic jump(input logic [15:0] step);
      jumpStep = step;
      jumpGo = 1'b1;
      tick(1);
      jumpGo = 1'b0;
   endtask
   task automatic end_sim();
      if (failures == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////
   // A jump trips; with alEn set the events pair, counters step, the trip ends after its hold
   task automatic t_jump(input logic [15:0] step, input logic alEn);
      logic [31:0] off;
      off = 'x;
      alarmEnable = alEn;
      evQ.delete();
      jump(step);
      `WAITV(tripOut, 1'b1, 800)
      `CHK("trip", 1'b1, tripOut)
      `CHK("state", `VJD_CODE_TRIP, stateCode)
      `CHK("alarm", alEn, alarmOut)
      `CHK("start on", 1'b1, startOut)
      tick(4);
      expT++;
      expA = expA + {15'h0000, alEn};
      `CHK("trip evt", {`VJD_EVT_TRIP, 1'b1}, evQ[0][34:32])
      if (alEn) `CHK("pair stamp", evQ[0][31:0], evQ[1][31:0])
      `CHK("tripCnt", expT, tripCnt)
      `CHK("alarmCnt", expA, alarmCnt)
      `WAITV(tripOut, 1'b0, 300)
      tick(3);
      foreach (evQ[i]) if (evQ[i][34:32] == {`VJD_EVT_TRIP, 1'b0}) off = evQ[i][31:0];
      `CHK("hold ms", 32'h00000014, off - evQ[0][31:0])
      tick(600);
      `CHK("alarm end", 1'b0, alarmOut)
   endtask
   // External or undervoltage block suppresses a jump and is counted
   task automatic t_block(input logic ext, input logic [15:0] mag);
      extBlock = ext;
      magL12 = mag;
      `WAITV(blockedOut, 1'b1, 600)
      `CHK("blocked", 1'b1, blockedOut)
      `CHK("blk state", `VJD_CODE_BLOCKED, stateCode)
      `CHK("start", 1'b0, startOut)
      jump(16'h0800);
      tick(300);
      jump(16'hF800);
      tick(300);
      `CHK("no trip", expT, tripCnt)
      `CHK("still blocked", 1'b1, blockedOut)
      extBlock = 1'b0;
      magL12 = 16'h4000;
      `WAITV(blockedOut, 1'b0, 600)
      expB++;
      tick(2);
      `CHK("blockedCnt", expB, blockedCnt)
      tick(600);
   endtask
   // Live set change: a high trip level only alarms; a bad selection is flagged
   task automatic t_sets();
      alarmEnable = 1'b1;
      setWrData = {16'h7FFF, 16'h0100, 16'h251C, 4'h1};
      setWrIdx = 3'h3;
      setWrEn = 1'b1;
      tick(1);
      setWrData = {16'h7FFF, 16'h0100, 16'h251C, 4'hB};
      setWrIdx = 3'h5;
      tick(1);
      setWrData = {16'h01F4, 16'h01F4, 16'h251C, 4'h7};
      setWrIdx = 3'h6;
      tick(1);
      setWrEn = 1'b0;
      setSel = 3'h5;
      tick(2);
      `CHK("selInvalid", 1'b1, selInvalid)
      setSel = 3'h6;
      magL12 = 16'h1000;
      tick(20);
      `CHK("L1 only", 1'b0, blockedOut)
      magL12 = 16'h4000;
      setSel = 3'h3;
      tick(300);
      `CHK("sel ok", 1'b0, selInvalid)
      jump(16'h0800);
      `WAITV(alarmOut, 1'b1, 800)
      `CHK("alarm only", 1'b1, alarmOut)
      `CHK("alm state", `VJD_CODE_ALARM, stateCode)
      expA++;
      tick(600);
      `CHK("alarm set", expA, alarmCnt)
      `CHK("trip set", expT, tripCnt)
      setSel = 3'h0;
      tick(300);
      t_jump(16'hF800, 1'b1);
   endtask
   // Each counter clears by its own bit
   task automatic t_clear();
      cntClear = 3'h2;
      tick(2);
      cntClear = 3'h0;
      `CHK("trip clr", 16'h0000, tripCnt)
      `CHK("alarm kept", expA, alarmCnt)
      cntClear = 3'h5;
      tick(2);
      cntClear = 3'h0;
      `CHK("alarm clr", 16'h0000, alarmCnt)
      `CHK("blocked clr", 16'h0000, blockedCnt)
   endtask
   // Forced codes, ending on normal so nothing is left forced
   task automatic t_force();
      forceEn = 1'b1;
      for (int k = 1; k < 5; k++) begin
         forceCode = 2'(k);
         tick(4);
         `CHK("forced", 2'(k), stateCode)
      end
      forceEn = 1'b0;
   endtask
   ////////////////////////////////////////
   initial begin
      {nrst, jumpGo, setWrEn, extBlock, forceEn, forceCode, cntClear} = '0;
      {jumpStep, setSel, setWrIdx, setWrData, expA, expT, expB} = '0;
      {failures, checked, cycles} = '0;
      magLevel = 16'h4000;
      magL12 = 16'h4000;
      alarmEnable = 1'b1;
      tick(3);
      nrst = 1'b1;
      tick(600);
      t_jump(16'h0800, 1'b1);
      t_jump(16'hF800, 1'b0);
      t_block(1'b1, 16'h4000);
      t_block(1'b0, 16'h1000);
      t_sets();
      t_clear();
      t_force();
      end_sim();
   end
endmodule
bind vjd_detector vjd_detector_sva #(.MS_CYCLES(MS_CYCLES)) checker_i (.clk, .nrst,
   .alarmEnable, .extBlock, .forceEn, .alarmOut, .tripOut, .blockedOut, .startOut,
   .stateCode, .evtValid, .evtSource, .evtOn, .evtStamp);
